// ### logic/ebvme_regs.vh
// constants of the event buffer readout block
// assumes a single 125 MHz clock and plain control ports, no register bus
`ifndef EBVME_REGS_VH
`define EBVME_REGS_VH

// padding words
`define EBVME_FILLER 32'h00000000
`define EBVME_INVALID 32'hffffffff

// readout cycle kinds
`define EBVME_CYC_SINGLE 2'h0
`define EBVME_CYC_BLOCK 2'h1
`define EBVME_CYC_CHAIN 2'h2

// channel count and almost-full reset level
`define EBVME_NCH 6'h20
`define EBVME_AF_DEFAULT 16'h0040

`endif

// ### logic/ebvme_top.v
// event buffer with trigger loader, readout engine and interrupter
// assumes front end counters answer chan_sel in the same cycle,
// and that the bus side converts word handshakes to bus cycles
`timescale 1ns/1ps
`default_nettype none
`include "ebvme_regs.vh"

////////////////////////////////////////////////////////////////
// small first-word-fall-through fifo
module ebvme_fifo #(
  parameter W = 33,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire clr,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  // honest full and empty
  assign in_ready = (cnt_reg != DEPTH);
  assign out_valid = (cnt_reg != 0);
  assign out_data = mem[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  // pointers and level
  always @(posedge clk) begin
    if (rst || clr) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // ebvme_fifo

////////////////////////////////////////////////////////////////
module ebvme_top #(
  parameter DEPTH = 1024,
  parameter AW = 10,
  parameter BLKW = 16
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration
  input wire [31:0] chan_en,
  input wire hdr_en,
  input wire berr_en,
  input wire [4:0] geo_addr,
  input wire [15:0] af_level,
  input wire first_board,
  input wire last_board,
  input wire [2:0] irq_level,
  input wire [7:0] irq_vector,
  // module clear and aligned event count write
  input wire clr,
  input wire ec_wr,
  input wire [15:0] ec_value,
  // trigger and counter front end
  input wire trig,
  output reg [4:0] chan_sel,
  input wire [31:0] chan_data,
  // readout cycle request
  input wire cyc_start,
  input wire [1:0] cyc_kind,
  input wire [BLKW-1:0] block_byte_count,
  // readout words
  output reg dout_valid,
  input wire dout_ready,
  output reg [31:0] dout_data,
  output reg dout_last,
  output reg berr,
  // chain token
  input wire token_in,
  output reg token_out,
  // interrupter
  output reg irq_req,
  output reg [2:0] irq_lvl_out,
  input wire iack,
  input wire [2:0] iack_lvl,
  output reg iack_ack,
  output reg [7:0] iack_data,
  // status
  output reg data_ready,
  output reg almost_full,
  output reg busy
);
  // readout states
  localparam R_IDLE = 3'h0;
  localparam R_TOKW = 3'h1;
  localparam R_SEND = 3'h2;
  localparam R_BERR = 3'h3;
  localparam R_TOKN = 3'h4;

  reg [AW:0] wcnt_reg;
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [32:0] event_buffer [0:DEPTH-1];
  reg [15:0] aligned_event_count_reg;
  reg [15:0] ev_sent_reg;
  reg [15:0] trig_num_reg;
  reg build_reg;
  reg hdr_pend_reg;
  reg [2:0] rstate_reg;
  reg [BLKW-1:0] blk_left_reg;
  reg chain_reg;
  reg single_reg;
  reg pad_reg;
  wire mclr;
  wire [32:0] ff_in;
  wire ff_in_valid;
  wire ff_in_ready;
  wire ff_out_valid;
  wire [32:0] ff_out;
  wire buf_full;
  wire buf_empty;
  wire fill;
  wire drain;
  wire aligned;
  wire use_berr;
  wire [15:0] ev_limit;
  wire [32:0] head_word;
  wire at_limit;
  wire stop_now;
  wire slot;

  // padding word for this configuration
  function [31:0] pad_word;
    input h;
    begin
      pad_word = h ? `EBVME_FILLER : `EBVME_INVALID;
    end
  endfunction

  // module clear: clear input or count write
  assign mclr = clr || ec_wr;

  ////////////////////////////////////////////////////////////////
  // trigger loader: header then enabled channels
  assign ff_in = hdr_pend_reg ? {1'b1, geo_addr, 11'h000, trig_num_reg} : {1'b0, chan_data};
  assign ff_in_valid = build_reg && (hdr_pend_reg || chan_en[chan_sel]);

  always @(posedge clk) begin
    if (rst || mclr) begin
      build_reg <= 1'b0;
      hdr_pend_reg <= 1'b0;
      chan_sel <= 5'h00;
      trig_num_reg <= 16'h0000;
    end else if (!build_reg) begin
      if (trig) begin
        build_reg <= 1'b1;
        hdr_pend_reg <= hdr_en;
        chan_sel <= 5'h00;
        trig_num_reg <= trig_num_reg + 16'h0001;
      end
    end else if (ff_in_ready || !ff_in_valid) begin
      // a full fifo stalls the loader here
      if (hdr_pend_reg) begin
        hdr_pend_reg <= 1'b0;
      end else begin
        chan_sel <= chan_sel + 5'h01;
        if (chan_sel == 5'h1f) build_reg <= 1'b0;
      end
    end
  end

  ebvme_fifo #(
    .W(33),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .clr(mclr),
    .in_valid(ff_in_valid),
    .in_ready(ff_in_ready),
    .in_data(ff_in),
    .out_valid(ff_out_valid),
    .out_ready(!buf_full),
    .out_data(ff_out)
  );

  ////////////////////////////////////////////////////////////////
  // event buffer storage
  assign buf_full = (wcnt_reg == DEPTH);
  assign buf_empty = (wcnt_reg == 0);
  assign fill = ff_out_valid && !buf_full;
  assign head_word = event_buffer[rp_reg];

  always @(posedge clk) begin
    if (fill) begin
      event_buffer[wp_reg] <= ff_out;
    end
  end

  // pointers; reset and clear leave it empty
  always @(posedge clk) begin
    if (rst || mclr) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      wcnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (fill) wp_reg <= wp_reg + 1'b1;
      if (drain) rp_reg <= rp_reg + 1'b1;
      if (fill && !drain) wcnt_reg <= wcnt_reg + 1'b1;
      else if (drain && !fill) wcnt_reg <= wcnt_reg - 1'b1;
    end
  end

  // aligned event count register, zero disables
  always @(posedge clk) begin
    if (rst) begin
      aligned_event_count_reg <= 16'h0000;
    end else if (ec_wr) begin
      aligned_event_count_reg <= ec_value;
    end
  end

  ////////////////////////////////////////////////////////////////
  // readout decisions
  assign aligned = hdr_en && (aligned_event_count_reg != 16'h0000);
  assign use_berr = berr_en || chain_reg;
  assign ev_limit = chain_reg ? 16'h0001 : aligned_event_count_reg;
  assign at_limit = (aligned || chain_reg) && head_word[32] && (ev_sent_reg >= ev_limit);
  assign stop_now = pad_reg || buf_empty || at_limit;
  assign slot = !dout_valid || dout_ready;
  assign drain = (rstate_reg == R_SEND) && slot && (blk_left_reg != 0) && !stop_now;

  // readout engine
  always @(posedge clk) begin
    if (rst || mclr) begin
      rstate_reg <= R_IDLE;
      blk_left_reg <= {BLKW{1'b0}};
      chain_reg <= 1'b0;
      single_reg <= 1'b0;
      pad_reg <= 1'b0;
      ev_sent_reg <= 16'h0000;
      dout_valid <= 1'b0;
      dout_data <= 32'h00000000;
      dout_last <= 1'b0;
      berr <= 1'b0;
      token_out <= 1'b0;
    end else begin
      berr <= 1'b0;
      token_out <= 1'b0;
      if (dout_valid && dout_ready) dout_valid <= 1'b0;
      case (rstate_reg)
        R_IDLE: begin
          pad_reg <= 1'b0;
          if (cyc_start) begin
            chain_reg <= (cyc_kind == `EBVME_CYC_CHAIN);
            single_reg <= (cyc_kind == `EBVME_CYC_SINGLE);
            // an aligned transfer resumes across blocks until done
            if (ev_sent_reg >= aligned_event_count_reg) ev_sent_reg <= 16'h0000;
            case (cyc_kind)
              `EBVME_CYC_SINGLE: begin
                blk_left_reg <= {{(BLKW-1){1'b0}}, 1'b1};
                rstate_reg <= R_SEND;
              end
              `EBVME_CYC_BLOCK: begin
                blk_left_reg <= {2'b00, block_byte_count[BLKW-1:2]};
                rstate_reg <= R_SEND;
              end
              `EBVME_CYC_CHAIN: begin
                blk_left_reg <= {BLKW{1'b1}};
                rstate_reg <= R_TOKW;
              end
              default: begin
                rstate_reg <= R_IDLE;
              end
            endcase
          end
        end
        R_TOKW: begin
          // first board, unless also last, holds the token; others wait for it
          if (first_board && !last_board || token_in) begin
            ev_sent_reg <= 16'h0000;
            if (!first_board && !last_board || buf_empty || !hdr_en) begin
              rstate_reg <= last_board ? R_BERR : R_TOKN;
            end else begin
              rstate_reg <= R_SEND;
            end
          end
        end
        R_SEND: begin
          if (slot) begin
            if (blk_left_reg == 0) begin
              rstate_reg <= R_IDLE;
            end else if (!stop_now) begin
              dout_valid <= 1'b1;
              dout_data <= head_word[31:0];
              dout_last <= (blk_left_reg == 1);
              blk_left_reg <= blk_left_reg - 1'b1;
              if (head_word[32]) ev_sent_reg <= ev_sent_reg + 16'h0001;
            end else if (chain_reg) begin
              // own events done: pass on, or end chain as last
              rstate_reg <= last_board ? R_BERR : R_TOKN;
            end else if (use_berr && !pad_reg) begin
              rstate_reg <= R_BERR;
            end else begin
              pad_reg <= 1'b1;
              dout_valid <= 1'b1;
              dout_data <= pad_word(hdr_en);
              dout_last <= (blk_left_reg == 1);
              blk_left_reg <= blk_left_reg - 1'b1;
            end
          end
        end
        R_BERR: begin
          if (slot) begin
            berr <= 1'b1;
            rstate_reg <= R_IDLE;
          end
        end
        R_TOKN: begin
          if (slot) begin
            token_out <= 1'b1;
            rstate_reg <= R_IDLE;
          end
        end
        default: begin
          rstate_reg <= R_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupter and status
  always @(posedge clk) begin
    if (rst) begin
      irq_req <= 1'b0;
      irq_lvl_out <= 3'h0;
      iack_ack <= 1'b0;
      iack_data <= 8'h00;
      data_ready <= 1'b0;
      almost_full <= 1'b0;
      busy <= 1'b0;
    end else begin
      almost_full <= ({{(15-AW){1'b0}}, wcnt_reg} >= af_level);
      // level request, held while count stays at or above level
      irq_req <= (irq_level != 3'h0) && !mclr && ({{(15-AW){1'b0}}, wcnt_reg} >= af_level);
      irq_lvl_out <= irq_level;
      iack_ack <= iack && irq_req && (iack_lvl == irq_level);
      if (iack && irq_req && (iack_lvl == irq_level)) iack_data <= irq_vector;
      data_ready <= !buf_empty;
      busy <= build_reg || (rstate_reg != R_IDLE);
    end
  end
endmodule // ebvme_top
`default_nettype wire

// ### testbench/ebvme_top_assertions.sv
// assertions on the ports of the event buffer readout block
// assumes a bind into ebvme_top and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module ebvme_chk (
  // clock and reset
  input wire clk,
  input wire rst,
  // inputs watched
  input wire clr,
  input wire ec_wr,
  input wire berr_en,
  input wire [1:0] cyc_kind,
  input wire dout_ready,
  input wire [2:0] irq_level,
  input wire [7:0] irq_vector,
  input wire iack,
  input wire [2:0] iack_lvl,
  // outputs watched
  input wire dout_valid,
  input wire [31:0] dout_data,
  input wire dout_last,
  input wire berr,
  input wire token_out,
  input wire irq_req,
  input wire iack_ack,
  input wire [7:0] iack_data,
  input wire data_ready,
  input wire almost_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // reset and clear empty the buffer
  a_rst_empty: assert property (disable iff (1'b0) rst |=> !data_ready && !irq_req && !dout_valid)
    else $error("outputs not idle after reset");
  a_clr_empties: assert property ((clr || ec_wr) |-> ##2 (!data_ready && !irq_req))
    else $error("clear left data or request");
  // interrupt request
  a_irq_on_full: assert property ($rose(almost_full) && irq_level != 3'h0 |-> ##[0:1] irq_req)
    else $error("no request at almost full");
  a_irq_release: assert property ($fell(almost_full) |-> ##[0:1] !irq_req)
    else $error("request kept below level");
  a_irq_disabled: assert property (irq_level == 3'h0 |=> !irq_req)
    else $error("request while disabled");
  a_iack_answer: assert property (iack && iack_lvl == irq_level && irq_req
    |-> ##[1:2] (iack_ack && iack_data == irq_vector))
    else $error("acknowledge not answered with vector");
  // readout words and endings
  a_word_hold: assert property (dout_valid && !dout_ready && !clr && !ec_wr
    |=> dout_valid && $stable(dout_data) && $stable(dout_last))
    else $error("word changed before taken");
  a_berr_cause: assert property (berr |-> berr_en || cyc_kind == 2'h2)
    else $error("bus error while disabled");
  a_berr_pulse: assert property (berr |=> !berr)
    else $error("bus error longer than a cycle");
  a_token_pulse: assert property (token_out |=> !token_out)
    else $error("token longer than a cycle");
endmodule // ebvme_chk
bind ebvme_top ebvme_chk i_ebvme_chk (.clk, .rst, .clr, .ec_wr, .berr_en, .cyc_kind, .dout_ready,
  .irq_level, .irq_vector, .iack, .iack_lvl, .dout_valid, .dout_data, .dout_last, .berr,
  .token_out, .irq_req, .iack_ack, .iack_data, .data_ready, .almost_full);
`default_nettype wire

// ### testbench/ebvme_master.sv
// bus master model that starts readout cycles and takes words
// assumes the word handshake of ebvme_top, driven 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module ebvme_master (
  // clock
  input wire logic clk,
  // cycle request and chain token
  output logic cyc_start,
  output logic [1:0] cyc_kind,
  output logic [15:0] block_byte_count,
  output logic token_in,
  // readout words
  input wire logic dout_valid,
  output logic dout_ready,
  input wire logic [31:0] dout_data,
  input wire logic dout_last,
  input wire logic berr,
  input wire logic token_out
);
  logic [31:0] q[$];
  logic got_berr;
  logic got_tok;
  ////////////////////////////////////////
  // idle at time zero
  initial begin
    cyc_start = 0;
    cyc_kind = 0;
    block_byte_count = 0;
    token_in = 0;
    dout_ready = 0;
  end
  // one cycle; slow drops ready every other clock cycle, tok hands the token one cycle after the start
  task automatic rd(input logic [1:0] k, input logic [15:0] nb, input logic slow, input logic tok);
    int t;
    int n;
    q.delete();
    got_berr = 0;
    got_tok = 0;
    n = 0;
    cyc_kind = k;
    block_byte_count = nb;
    cyc_start = 1;
    @(posedge clk);
    #1;
    cyc_start = 0;
    // a waiting board leaves its token wait only on token_in
    if (tok) begin
      token_in = 1;
      @(posedge clk);
      #1;
      token_in = 0;
    end
    for (t = 0; t < 300 && n < 4; t++) begin
      dout_ready = slow ? ~dout_ready : 1'b1;
      @(posedge clk);
      if (dout_valid === 1'b1 && dout_ready === 1'b1) q.push_back(dout_data);
      if (berr === 1'b1) got_berr = 1;
      if (token_out === 1'b1) got_tok = 1;
      // last counts only on a taken word, a stale last flag must not end the cycle
      if (n > 0 || got_berr || got_tok || (dout_valid === 1'b1 && dout_last === 1'b1 && dout_ready === 1'b1 && k != 2'h2)) n++;
      #1;
    end
    dout_ready = 0;
    if (k == 2'h2 && q.size() % 2 == 1) q.push_back(32'h00000000);
  endtask
endmodule // ebvme_master
`default_nettype wire

// ### testbench/event_buffer_vme_readout_tb_top.sv
// self-checking bench for the event buffer readout block
// assumes ebvme_top, the master model and the checker bind
`timescale 1ns/1ps
`default_nettype none
`include "ebvme_regs.vh"
module event_buffer_vme_readout_tb_top;
  logic clk, rst, hdr_en, berr_en, first_board, last_board, clr, ec_wr, trig, iack;
  logic [15:0] af_level, ec_value;
  logic [2:0] irq_level, iack_lvl;
  logic [31:0] want_q[$];
  int n_fail, total_checks, cycles;
  wire [4:0] chan_sel;
  wire [31:0] dout_data;
  wire [7:0] iack_data;
  wire [1:0] cyc_kind;
  wire [15:0] bbc;
  wire dout_valid, dout_last, berr, token_out, irq_req, iack_ack, data_ready, dout_ready, cyc_start, token_in;
  wire almost_full;
  // front end answers with a pattern of the channel number
  wire [31:0] chan_data = {27'h0060000, chan_sel};
  ////////////////////////////////////////
  ebvme_top i_ebvme_top (.clk(clk), .rst(rst), .chan_en(32'h80000001), .hdr_en(hdr_en), .berr_en(berr_en),
    .geo_addr(5'h15), .af_level(af_level), .first_board(first_board), .last_board(last_board),
    .irq_level(irq_level), .irq_vector(8'h5a), .clr(clr), .ec_wr(ec_wr), .ec_value(ec_value), .trig(trig),
    .chan_sel(chan_sel), .chan_data(chan_data), .cyc_start(cyc_start), .cyc_kind(cyc_kind),
    .block_byte_count(bbc), .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_data(dout_data),
    .dout_last(dout_last), .berr(berr), .token_in(token_in), .token_out(token_out), .irq_req(irq_req),
    .irq_lvl_out(), .iack(iack), .iack_lvl(iack_lvl), .iack_ack(iack_ack), .iack_data(iack_data),
    .data_ready(data_ready), .almost_full(almost_full), .busy());
  ebvme_master i_ebvme_master (.clk(clk), .cyc_start(cyc_start), .cyc_kind(cyc_kind), .block_byte_count(bbc),
    .token_in(token_in), .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_data(dout_data),
    .dout_last(dout_last), .berr(berr), .token_out(token_out));
  ////////////////////////////////////////
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic pclr;
    clr = 1;
    tick(1);
    clr = 0;
    tick(3);
  endtask
  task automatic trg;
    trig = 1;
    tick(1);
    trig = 0;
    tick(45);
  endtask
  task automatic ev(input logic [15:0] n);
    if (hdr_en) want_q.push_back({5'h15, 11'h0, n});
    want_q.push_back(32'h00c00000);
    want_q.push_back(32'h00c0001f);
  endtask
  task automatic pad(input int n, input logic [31:0] w);
    repeat (n) want_q.push_back(w);
  endtask
  task automatic rd(input logic [1:0] k, input logic [15:0] nb, input logic s, input logic t);
    i_ebvme_master.rd(k, nb, s, t);
  endtask
  task automatic cmpq;
    chk(i_ebvme_master.q.size(), want_q.size());
    foreach (want_q[i]) chk(i_ebvme_master.q[i], want_q[i]);
    want_q.delete();
  endtask
  ////////////////////////////////////////
  // scenarios
  task automatic t_empty;
    chk(data_ready, 0);
    rd(`EBVME_CYC_SINGLE, 16'h0004, 0, 0);
    pad(1, `EBVME_INVALID);
    cmpq;
    berr_en = 1;
    rd(`EBVME_CYC_SINGLE, 16'h0004, 0, 0);
    chk(i_ebvme_master.got_berr, 1);
    cmpq;
    berr_en = 0;
  endtask
  task automatic t_block(input logic h);
    hdr_en = h;
    pclr;
    trg;
    rd(`EBVME_CYC_BLOCK, 16'h0018, 1, 0);
    ev(1);
    pad(h ? 3 : 4, h ? `EBVME_FILLER : `EBVME_INVALID);
    cmpq;
  endtask
  task automatic t_berr;
    berr_en = 1;
    pclr;
    trg;
    rd(`EBVME_CYC_BLOCK, 16'h0028, 1, 0);
    ev(1);
    cmpq;
    chk(i_ebvme_master.got_berr, 1);
    berr_en = 0;
  endtask
  task automatic t_align;
    // aligned mode and chained reads both need the header
    hdr_en = 1;
    trg;
    ec_value = 16'h0001;
    ec_wr = 1;
    tick(1);
    ec_wr = 0;
    tick(2);
    chk(data_ready, 0);
    trg;
    trg;
    rd(`EBVME_CYC_BLOCK, 16'h0018, 0, 0);
    ev(1);
    pad(3, `EBVME_FILLER);
    cmpq;
    berr_en = 1;
    rd(`EBVME_CYC_BLOCK, 16'h0028, 0, 0);
    ev(2);
    cmpq;
    chk(i_ebvme_master.got_berr, 1);
    berr_en = 0;
    ec_value = 16'h0000;
    ec_wr = 1;
    tick(1);
    ec_wr = 0;
    tick(3);
  endtask
  task automatic t_chain;
    trg;
    trg;
    first_board = 1;
    rd(`EBVME_CYC_CHAIN, 16'h0100, 1, 0);
    ev(1);
    pad(1, `EBVME_FILLER);
    cmpq;
    chk(i_ebvme_master.got_tok, 1);
    first_board = 0;
    rd(`EBVME_CYC_CHAIN, 16'h0100, 0, 1);
    cmpq;
    chk(i_ebvme_master.got_tok, 1);
    last_board = 1;
    rd(`EBVME_CYC_CHAIN, 16'h0100, 0, 1);
    ev(2);
    pad(1, `EBVME_FILLER);
    cmpq;
    chk(i_ebvme_master.got_berr, 1);
    last_board = 0;
  endtask
  task automatic t_irq;
    int i;
    af_level = 16'h0003;
    pclr;
    trg;
    chk(irq_req, 0);
    irq_level = 3'h5;
    tick(3);
    chk(irq_req, 1);
    chk(almost_full, 1);
    iack_lvl = 3'h5;
    iack = 1;
    tick(1);
    iack = 0;
    for (i = 0; i < 4 && iack_ack !== 1'b1; i++) tick(1);
    chk(iack_data, 32'h5a);
    rd(`EBVME_CYC_SINGLE, 16'h0004, 0, 0);
    pad(1, {5'h15, 11'h0, 16'h0001});
    cmpq;
    tick(2);
    chk(irq_req, 0);
    pclr;
    trg;
    chk(irq_req, 1);
    pclr;
    chk(irq_req, 0);
    chk(almost_full, 0);
    irq_level = 3'h0;
    af_level = `EBVME_AF_DEFAULT;
  endtask
  ////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // clock
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // cycle ceiling
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      stop_test;
    end
  end
  // main sequence
  initial begin
    {rst, hdr_en, berr_en, first_board, last_board, clr, ec_wr, trig, iack} = 9'h100;
    af_level = `EBVME_AF_DEFAULT;
    ec_value = 16'h0000;
    irq_level = 3'h0;
    iack_lvl = 3'h0;
    repeat (4) @(posedge clk);
    #1;
    rst = 0;
    t_empty;
    t_block(1);
    t_block(0);
    t_berr;
    t_align;
    t_chain;
    t_irq;
    stop_test;
  end
endmodule // event_buffer_vme_readout_tb_top
`default_nettype wire
